/* File: core/viu_regs.vh */
// Register map, field positions and timing constants of the interrupt unit
`ifndef VIU_REGS_VH
`define VIU_REGS_VH
// Register byte offsets
`define VIU_ADR_EN        8'hA8
`define VIU_ADR_PR        8'hB8
`define VIU_ADR_XEN_A     8'hC0
`define VIU_ADR_XEN_B     8'hC4
`define VIU_ADR_XPR_A     8'hC8
`define VIU_ADR_XPR_B     8'hCC
`define VIU_ADR_PEND      8'hD0
`define VIU_ADR_EVT_STAT  8'hE0
`define VIU_ADR_EVT_CLR   8'hE4
`define VIU_ADR_EVT_EN    8'hE8
// Reset values
`define VIU_EN_RST        8'h00
`define VIU_PR_RST        8'h00
`define VIU_X_RST         8'h00
// Enable and priority register fields
`define VIU_EN_GLOBAL     7
`define VIU_PR_UNUSED     7
// Reserved slot: bit 2 of the second extended registers
`define VIU_XB_MASK       8'h3B
// Priority register: writable bits and the bit that reads as one
`define VIU_PR_MASK       8'h7F
`define VIU_PR_RD_ONE     8'h80
// Pending flag positions
`define VIU_F_PIN0        0
`define VIU_F_T0          1
`define VIU_F_PIN1        2
`define VIU_F_T1          3
`define VIU_F_URX         4
`define VIU_F_UTX         5
`define VIU_F_T2L         6
`define VIU_F_T2H         7
`define VIU_F_SPI_LO      8
`define VIU_F_SPI_HI      11
`define VIU_F_EXT_LO      12
`define VIU_F_EXT_HI      25
`define VIU_NFLAG         26
// Source count (pin 0 .. timer 5) and reserved source index
`define VIU_NSRC          21
`define VIU_SRC_RSVD      17
// Vector of the first source, spacing as a shift, reset vector
`define VIU_VEC_BASE      16'h0003
`define VIU_VEC_SHIFT     3
`define VIU_VEC_RESET     16'h0000
// Call time after detection
`define VIU_CLK_NS        10
`define VIU_CALL_NS       50
`define VIU_CALL_CYC      (`VIU_CALL_NS / `VIU_CLK_NS)
// Last value of the call counter, which counts the five call cycles from 0
`define VIU_CALL_LAST     3'h4
// Event status bits
`define VIU_EV_ENTER      0
`define VIU_EV_RETURN     1
`endif

/* File: core/viu_top.v */
// Interrupt enable, priority arbitration and vector generation unit
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.vh"
module viu_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [7:0]  adr_i,
   input  wire [31:0] dat_i,
   input  wire [3:0]  sel_i,
   input  wire        we_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire        pin_irq0_input_i,
   input  wire        pin_irq1_input_i,
   input  wire        timer0_overflow_flag_i,
   input  wire        timer1_overflow_flag_i,
   input  wire        uart_rx_done_i,
   input  wire        uart_tx_done_i,
   input  wire        timer2_low_overflow_flag_i,
   input  wire        timer2_high_overflow_flag_i,
   input  wire        serial_periph_done_flag_i,
   input  wire        serial_periph_write_collision_i,
   input  wire        serial_periph_mode_fault_i,
   input  wire        serial_periph_rx_overrun_i,
   input  wire [13:0] ext_src_evt_i,
   input  wire        isr_return_i,
   output reg         isr_enter_o,
   output reg  [15:0] isr_vector_o,
   output reg         isr_level_o,
   output reg         irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte-lane merge of a 32-bit write into an old value
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      b;
      begin
         lane_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // Winner: high level first, then lowest index; bit 5 = found
   function [5:0] arbitrate;
      input [`VIU_NSRC-1:0] req;
      input [`VIU_NSRC-1:0] lvl;
      integer               i;
      reg                   got_hi;
      reg                   got_any;
      begin
         arbitrate = 6'h00;
         got_hi    = 1'b0;
         got_any   = 1'b0;
         for (i = `VIU_NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && lvl[i]) begin
               arbitrate = {1'b1, i[4:0]};
               got_hi    = 1'b1;
            end
         end
         for (i = `VIU_NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && !got_hi) begin
               arbitrate = {1'b1, i[4:0]};
               got_any   = 1'b1;
            end
         end
         if (!got_hi && !got_any) begin
            arbitrate = 6'h00;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers

   localparam ST_IDLE = 1'b0;
   localparam ST_CALL = 1'b1;

   reg [7:0]             en_ff;
   reg [7:0]             pr_ff;
   reg [7:0]             xen_a_ff;
   reg [7:0]             xen_b_ff;
   reg [7:0]             xpr_a_ff;
   reg [7:0]             xpr_b_ff;
   reg [`VIU_NFLAG-1:0]  pend_ff;
   reg [1:0]             evt_stat_ff;
   reg [1:0]             evt_en_ff;
   reg                   state_ff;
   reg [2:0]             call_cnt_ff;
   reg [4:0]             win_idx_ff;
   reg                   win_lvl_ff;
   reg                   isr_lo_ff;
   reg                   isr_hi_ff;

   reg [`VIU_NFLAG-1:0]  nxt_pend;
   reg [`VIU_NFLAG-1:0]  hw_set;
   reg [`VIU_NFLAG-1:0]  auto_clr;
   reg [`VIU_NSRC-1:0]   src_flag;
   reg [`VIU_NSRC-1:0]   src_en;
   reg [`VIU_NSRC-1:0]   src_lvl;
   reg [`VIU_NSRC-1:0]   src_req;
   reg [31:0]            rd_data;
   reg [31:0]            pend_wr;
   reg [1:0]             evt_set;
   wire [5:0]            win;
   wire                  can_take;
   wire                  bus_req;
   wire                  wr_en;
   wire                  call_done;

   assign bus_req = cyc_i & stb_i & ~ack_o;
   assign wr_en   = bus_req & we_i;

   ////////////////////////////////////////////////////////////////////////
   // Flag set sources, source requests and masks

   always @* begin
      hw_set = {`VIU_NFLAG{1'b0}};
      hw_set[`VIU_F_PIN0] = pin_irq0_input_i;
      hw_set[`VIU_F_T0]   = timer0_overflow_flag_i;
      hw_set[`VIU_F_PIN1] = pin_irq1_input_i;
      hw_set[`VIU_F_T1]   = timer1_overflow_flag_i;
      hw_set[`VIU_F_URX]  = uart_rx_done_i;
      hw_set[`VIU_F_UTX]  = uart_tx_done_i;
      hw_set[`VIU_F_T2L]  = timer2_low_overflow_flag_i;
      hw_set[`VIU_F_T2H]  = timer2_high_overflow_flag_i;
      hw_set[`VIU_F_SPI_HI:`VIU_F_SPI_LO] = {serial_periph_rx_overrun_i,
         serial_periph_mode_fault_i, serial_periph_write_collision_i,
         serial_periph_done_flag_i};
      hw_set[`VIU_F_EXT_HI:`VIU_F_EXT_LO] = ext_src_evt_i;
      // Reserved slot never holds a flag
      hw_set[`VIU_F_EXT_LO + `VIU_SRC_RSVD - 7] = 1'b0;
   end

   // Per-source flag, enable and level
   always @* begin
      src_flag[0] = pend_ff[`VIU_F_PIN0];
      src_flag[1] = pend_ff[`VIU_F_T0];
      src_flag[2] = pend_ff[`VIU_F_PIN1];
      src_flag[3] = pend_ff[`VIU_F_T1];
      src_flag[4] = pend_ff[`VIU_F_URX] | pend_ff[`VIU_F_UTX];
      src_flag[5] = pend_ff[`VIU_F_T2L] | pend_ff[`VIU_F_T2H];
      src_flag[6] = |pend_ff[`VIU_F_SPI_HI:`VIU_F_SPI_LO];
      src_flag[`VIU_NSRC-1:7] = pend_ff[`VIU_F_EXT_HI:`VIU_F_EXT_LO];
      // Bits 0..6 of the enable register map to sources 0..6
      src_en  = {xen_b_ff[5:0], xen_a_ff, en_ff[6:0]};
      src_lvl = {xpr_b_ff[5:0], xpr_a_ff, pr_ff[6:0]};
      src_req = src_flag & src_en &
                {`VIU_NSRC{en_ff[`VIU_EN_GLOBAL]}};
      src_req[`VIU_SRC_RSVD] = 1'b0;
   end

   assign win = arbitrate(src_req, src_lvl);
   // High may preempt low; nothing preempts high
   assign can_take = win[5] & ~isr_hi_ff &
                     (src_lvl[win[4:0]] | ~isr_lo_ff);
   assign call_done = (state_ff == ST_CALL) &&
                      (call_cnt_ff == `VIU_CALL_LAST);

   // Auto-clear of pin and timer 0/1 flags on entry
   always @* begin
      auto_clr = {`VIU_NFLAG{1'b0}};
      if (call_done) begin
         case (win_idx_ff)
            5'h00: auto_clr[`VIU_F_PIN0] = 1'b1;
            5'h01: auto_clr[`VIU_F_T0]   = 1'b1;
            5'h02: auto_clr[`VIU_F_PIN1] = 1'b1;
            5'h03: auto_clr[`VIU_F_T1]   = 1'b1;
            default: auto_clr = {`VIU_NFLAG{1'b0}};
         endcase
      end
   end

   // Pending flags: auto-clear, software write, hardware set wins
   always @* begin
      pend_wr  = lane_merge({{(32-`VIU_NFLAG){1'b0}}, pend_ff}, dat_i,
                            sel_i);
      nxt_pend = pend_ff & ~auto_clr;
      if (wr_en && adr_i == `VIU_ADR_PEND) begin
         nxt_pend = pend_wr[`VIU_NFLAG-1:0];
      end
      nxt_pend = nxt_pend | hw_set;
      nxt_pend[`VIU_F_EXT_LO + `VIU_SRC_RSVD - 7] = 1'b0;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pend_ff <= {`VIU_NFLAG{1'b0}};
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: writes, read mux, ack

   always @(posedge clk_i) begin
      if (rst_i) begin
         en_ff    <= `VIU_EN_RST;
         pr_ff    <= `VIU_PR_RST;
         xen_a_ff <= `VIU_X_RST;
         xen_b_ff <= `VIU_X_RST;
         xpr_a_ff <= `VIU_X_RST;
         xpr_b_ff <= `VIU_X_RST;
         evt_en_ff <= 2'h0;
      end else if (wr_en && sel_i[0]) begin
         case (adr_i)
            `VIU_ADR_EN:     en_ff    <= dat_i[7:0];
            `VIU_ADR_PR:     pr_ff    <= dat_i[7:0] & `VIU_PR_MASK;
            `VIU_ADR_XEN_A:  xen_a_ff <= dat_i[7:0];
            `VIU_ADR_XEN_B:  xen_b_ff <= dat_i[7:0] & `VIU_XB_MASK;
            `VIU_ADR_XPR_A:  xpr_a_ff <= dat_i[7:0];
            `VIU_ADR_XPR_B:  xpr_b_ff <= dat_i[7:0] & `VIU_XB_MASK;
            `VIU_ADR_EVT_EN: evt_en_ff <= dat_i[1:0];
            default:         en_ff    <= en_ff;
         endcase
      end
   end

   // Read mux; unmapped reads return zero
   always @* begin
      rd_data = 32'h0000_0000;
      case (adr_i)
         `VIU_ADR_EN:       rd_data[7:0] = en_ff;
         `VIU_ADR_PR:       rd_data[7:0] = pr_ff | `VIU_PR_RD_ONE; // Unused 1
         `VIU_ADR_XEN_A:    rd_data[7:0] = xen_a_ff;
         `VIU_ADR_XEN_B:    rd_data[7:0] = xen_b_ff;
         `VIU_ADR_XPR_A:    rd_data[7:0] = xpr_a_ff;
         `VIU_ADR_XPR_B:    rd_data[7:0] = xpr_b_ff;
         `VIU_ADR_PEND:     rd_data[`VIU_NFLAG-1:0] = pend_ff;
         `VIU_ADR_EVT_STAT: rd_data[1:0] = evt_stat_ff;
         `VIU_ADR_EVT_EN:   rd_data[1:0] = evt_en_ff;
         default:           rd_data = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= bus_req ? rd_data : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Detection and call sequence

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff     <= ST_IDLE;
         call_cnt_ff  <= 3'h0;
         win_idx_ff   <= 5'h00;
         win_lvl_ff   <= 1'b0;
         isr_enter_o  <= 1'b0;
         isr_vector_o <= `VIU_VEC_RESET;
         isr_level_o  <= 1'b0;
      end else begin
         isr_enter_o <= 1'b0;
         case (state_ff)
            // One cycle of detection
            ST_IDLE: begin
               call_cnt_ff <= 3'h0;
               if (can_take) begin
                  win_idx_ff <= win[4:0];
                  win_lvl_ff <= src_lvl[win[4:0]];
                  state_ff   <= ST_CALL;
               end
            end
            // Five cycles of call, then entry
            ST_CALL: begin
               call_cnt_ff <= call_cnt_ff + 3'h1;
               if (call_done) begin
                  isr_enter_o  <= 1'b1;
                  isr_vector_o <= `VIU_VEC_BASE +
                     ({11'h000, win_idx_ff} << `VIU_VEC_SHIFT);
                  isr_level_o  <= win_lvl_ff;
                  state_ff     <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // In-service levels; return closes the highest active level
   always @(posedge clk_i) begin
      if (rst_i) begin
         isr_lo_ff <= 1'b0;
         isr_hi_ff <= 1'b0;
      end else begin
         // Return first, so an entry in the same cycle is not lost
         if (isr_return_i) begin
            if (isr_hi_ff) begin
               isr_hi_ff <= 1'b0;
            end else begin
               isr_lo_ff <= 1'b0;
            end
         end
         if (call_done) begin
            if (win_lvl_ff) begin
               isr_hi_ff <= 1'b1;
            end else begin
               isr_lo_ff <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event status, clear, interrupt output

   always @* begin
      evt_set = 2'h0;
      evt_set[`VIU_EV_ENTER]  = call_done;
      evt_set[`VIU_EV_RETURN] = isr_return_i;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         evt_stat_ff <= 2'h0;
         irq_o       <= 1'b0;
      end else begin
         if (wr_en && sel_i[0] && adr_i == `VIU_ADR_EVT_CLR) begin
            evt_stat_ff <= (evt_stat_ff & ~dat_i[1:0]) | evt_set;
         end else begin
            evt_stat_ff <= evt_stat_ff | evt_set;
         end
         irq_o <= |(evt_stat_ff & evt_en_ff);
      end
   end

endmodule // viu_top
`default_nettype wire

/* File: tb/viu_checker.sv */
// Port-level checker for the interrupt enable unit
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.vh"
module viu_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0]  sel_i,
   input wire logic        we_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        isr_enter_o,
   input wire logic [15:0] isr_vector_o,
   input wire logic        isr_level_o,
   input wire logic        irq_o
);
   logic [7:0] en_sh_ff;
   logic [7:0] een_sh_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   // Shadow copies of enables, stored with the taken write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_sh_ff <= 8'h00;
         een_sh_ff <= 8'h00;
      end else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]) begin
         if (adr_i == `VIU_ADR_EN) en_sh_ff <= dat_i[7:0];
         if (adr_i == `VIU_ADR_EVT_EN) een_sh_ff <= dat_i[7:0];
      end
   end
   sequence bus_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence call_quiet;
      !isr_enter_o [*5];
   endsequence
   ////////////////////////////////////////
   // Bus and interrupt path relations
   bus_ack_a: assert property (bus_take |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after request");
   ack_cause_a: assert property (!bus_take |=> !ack_o)
      else $error("ack without request");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   en_read_a: assert property (ack_o && !$past(we_i) &&
      $past(adr_i) == `VIU_ADR_EN |-> dat_o == {24'h0, en_sh_ff})
      else $error("enable register readback wrong");
   enter_gap_a: assert property (isr_enter_o |=> call_quiet)
      else $error("entries closer than call length");
   vec_legal_a: assert property (isr_enter_o |->
      isr_vector_o[2:0] == 3'h3 && isr_vector_o <= 16'h00A3 &&
      isr_vector_o != 16'h008B)
      else $error("illegal vector on entry");
   global_off_a: assert property (!en_sh_ff[7] [*7] |-> !isr_enter_o)
      else $error("entry with global enable off");
   vec_hold_a: assert property (!isr_enter_o |->
      $stable(isr_vector_o) && $stable(isr_level_o))
      else $error("vector changed without entry");
   irq_evt_a: assert property (isr_enter_o && een_sh_ff[0] |-> ##2 irq_o)
      else $error("irq missing after entry event");
   reset_out_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o &&
      !isr_enter_o && isr_vector_o == 16'h0000)
      else $error("outputs not at reset values");
endmodule // viu_checker
bind viu_top viu_checker chk_u (.*);
`default_nettype wire

/* File: tb/viu_core_model.sv */
// Processor core model: takes vector entries and returns after a delay
`timescale 1ns/10ps
`default_nettype none
module viu_core_model (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       isr_enter_i,
   input wire logic [7:0] dly_i,
   output var logic       isr_return_o
);
   logic [3:0] depth_ff;
   logic [7:0] cnt_ff;
   // Nested routine count, one return per delay
   always @(posedge clk_i) begin
      isr_return_o <= 1'b0;
      if (rst_i) begin
         depth_ff <= 4'h0;
         cnt_ff <= 8'h00;
      end else if (isr_enter_i) begin
         depth_ff <= depth_ff + 4'h1;
         cnt_ff <= dly_i;
      end else if (depth_ff != 4'h0) begin
         if (cnt_ff == 8'h00) begin
            isr_return_o <= 1'b1;
            depth_ff <= depth_ff - 4'h1;
            cnt_ff <= dly_i;
         end else begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule // viu_core_model
`default_nettype wire

/* File: tb/viu_top_test.sv */
// Self-checking testbench of the interrupt enable unit
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.vh"
module viu_top_test;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i;
   logic [7:0]  adr_i, seed, core_dly;
   logic [31:0] dat_i, rd;
   logic [3:0]  sel_i;
   logic [11:0] src;
   logic [13:0] ext_src_evt_i;
   int          fail_count, total_checks, n, k, b;
   wire [31:0]  dat_o;
   wire [15:0]  isr_vector_o;
   wire ack_o, isr_return_i, isr_enter_o, isr_level_o, irq_o;
   wire pin_irq0_input_i, timer0_overflow_flag_i, pin_irq1_input_i;
   wire timer1_overflow_flag_i, uart_rx_done_i, uart_tx_done_i;
   wire timer2_low_overflow_flag_i, timer2_high_overflow_flag_i;
   wire serial_periph_done_flag_i, serial_periph_write_collision_i;
   wire serial_periph_mode_fault_i, serial_periph_rx_overrun_i;
   // Flag inputs in pending-word order
   assign {serial_periph_rx_overrun_i, serial_periph_mode_fault_i,
      serial_periph_write_collision_i, serial_periph_done_flag_i,
      timer2_high_overflow_flag_i, timer2_low_overflow_flag_i,
      uart_tx_done_i, uart_rx_done_i, timer1_overflow_flag_i,
      pin_irq1_input_i, timer0_overflow_flag_i, pin_irq0_input_i} = src;
   viu_top DUT (.*);
   viu_core_model core_u (.clk_i(clk_i), .rst_i(rst_i),
      .isr_enter_i(isr_enter_o), .dly_i(core_dly),
      .isr_return_o(isr_return_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic int fbit(input int i, input logic [7:0] r);
      return i < 4 ? i : i == 4 ? 4 + r[0] : i == 5 ? 6 + r[0] : 8 + r[1:0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tmo;
      fail_count++;
      $display("[FAIL] wait expected answer seen timeout");
      close_out();
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
         if (++t > 40) tmo();
         @(posedge clk_i);
      end
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task automatic pulse(input logic [25:0] m);
      @(posedge clk_i);
      {ext_src_evt_i, src} <= m;
      @(posedge clk_i);
      {ext_src_evt_i, src} <= 26'h0;
   endtask
   task automatic wait_hi(input bit ret, input bit must, output int c);
      for (c = 1; c <= 40; c++) begin
         @(posedge clk_i);
         #1;
         if ((ret ? isr_return_i : isr_enter_o) === 1'b1) return;
      end
      c = 99;
      if (must) tmo();
   endtask
   task automatic settle;
      @(posedge clk_i);
      #1;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      tmo();
   end
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, src} = '0;
      ext_src_evt_i = 14'h0;
      {fail_count, total_checks} = '0;
      rst_i = 1'b1;
      seed = 8'h51;
      core_dly = 8'h01;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, `VIU_ADR_EN, 0);
      chk("enable reset", 32'h0, rd);
      wb(0, `VIU_ADR_PR, 0);
      chk("priority reset", 32'h80, rd);
      wb(0, 8'h00, 0);
      chk("unmapped read", 32'h0, rd);
      seed = lfsr(seed);
      wb(1, `VIU_ADR_EN, {24'h0, seed});
      wb(0, `VIU_ADR_EN, 0);
      chk("enable readback", {24'h0, seed}, rd);
      wb(1, `VIU_ADR_XEN_B, 32'hFF);
      wb(0, `VIU_ADR_XEN_B, 0);
      chk("reserved enable", 32'h3B, rd);
      wb(1, `VIU_ADR_EVT_EN, 1);
      // Each primary source: gated, masked, then vectored
      for (k = 0; k < 14; k++) begin
         seed = lfsr(seed);
         b = fbit(k % 7, seed);
         core_dly <= 8'h10 | (seed & 8'h0F);
         wb(1, `VIU_ADR_PEND, 0);
         wb(1, `VIU_ADR_EN, 32'h7F);
         pulse(26'h1 << b);
         wait_hi(0, 0, n);
         chk("global off", 99, n);
         wb(1, `VIU_ADR_EN, 32'h80 | (32'h7F & ~(32'h1 << (k % 7))));
         wait_hi(0, 0, n);
         chk("own bit off", 99, n);
         wb(0, `VIU_ADR_PEND, 0);
         chk("pending set", 32'h1 << b, rd);
         wb(1, `VIU_ADR_PEND, 0);
         wb(1, `VIU_ADR_EN, 32'h80 | (32'h1 << (k % 7)));
         pulse(26'h1 << b);
         wait_hi(0, 1, n);
         chk("latency", 6, n);
         chk("vector", 16'h0003 + ((k % 7) << 3), isr_vector_o);
         wb(0, `VIU_ADR_PEND, 0);
         chk("auto clear", (k % 7) < 4 ? 0 : 32'h1 << b, rd);
         wb(1, `VIU_ADR_PEND, 0);
         wait_hi(1, 1, n);
      end
      // Event status, mask and clear of the interrupt output
      settle();
      chk("irq raised", 1, irq_o);
      wb(0, `VIU_ADR_EVT_STAT, 0);
      chk("event status", 32'h3, rd);
      wb(1, `VIU_ADR_EVT_EN, 0);
      settle();
      chk("irq masked", 0, irq_o);
      wb(1, `VIU_ADR_EVT_CLR, 3);
      wb(1, `VIU_ADR_EVT_EN, 1);
      settle();
      chk("irq cleared", 0, irq_o);
      // Simultaneous timer 0 and pin 1, by list then by level
      core_dly <= 8'h01;
      for (k = 0; k < 2; k++) begin
         wb(1, `VIU_ADR_PR, k ? 32'h04 : 32'h00);
         wb(1, `VIU_ADR_EN, 32'h86);
         pulse(26'h6);
         wait_hi(0, 1, n);
         chk("first vector", k ? 16'h0013 : 16'h000B, isr_vector_o);
         chk("first level", k, isr_level_o);
         wait_hi(0, 1, n);
         chk("second vector", k ? 16'h000B : 16'h0013, isr_vector_o);
         wait_hi(0, 0, n);
         chk("no reentry", 99, n);
      end
      // Extended source and the reserved slot
      wb(1, `VIU_ADR_XEN_A, 1);
      pulse(26'h1 << 12);
      wait_hi(0, 1, n);
      chk("extended vector", 16'h003B, isr_vector_o);
      wb(1, `VIU_ADR_PEND, 0);
      pulse(26'h1 << 22);
      wait_hi(0, 0, n);
      chk("reserved quiet", 99, n);
      // High extended source preempts a running low routine
      core_dly <= 8'h20;
      wb(1, `VIU_ADR_XPR_A, 1);
      wb(1, `VIU_ADR_EN, 32'h82);
      pulse(26'h2);
      wait_hi(0, 1, n);
      chk("low entry", 16'h000B, isr_vector_o);
      pulse(26'h1 << 12);
      wait_hi(0, 1, n);
      chk("preempt latency", 6, n);
      chk("preempt vector", 16'h003B, isr_vector_o);
      chk("preempt level", 1, isr_level_o);
      wb(1, `VIU_ADR_PEND, 0);
      wait_hi(1, 1, n);
      wait_hi(1, 1, n);
      wait_hi(0, 0, n);
      chk("no resume", 99, n);
      wb(1, `VIU_ADR_XPR_B, 32'hFF);
      wb(0, `VIU_ADR_XPR_B, 0);
      chk("reserved priority", 32'h3B, rd);
      close_out();
   end
endmodule // viu_top_test
`default_nettype wire
